// >>> hw/port_set_pkg.sv
// Constants for the open-drain port set with key-on wakeup
// Summary of operation
// - Open-drain pins; latch 1 releases for input
// - Four bit-addressable pins, one selected latch each
// - Two-bit port, two four-bit ports, open-drain
// - Timer pin toggles on each underflow
// - Interrupt pin requests interrupt and backup return
// - Wake/pull-up port: switchable wakeup and pull-ups
// - Logic port: switchable wakeup, feeds logic op
// - Logic op combines port with accumulator
// - Single-bit ports share pins, either latch pulls low
// - Shared pins stay usable under alternate functions
// - Wakeup bit 1 covers wake port bits 1-3
// - Wakeup bit 0 covers all logic port pins
// - Low enabled pin ends backup at once
// - Pull-up bit 0 enables wake port pull-ups
// - Pull-up bit 1 enables single-bit port pull-ups
package port_set_pkg;
  localparam int PortW = 4;
  localparam int TwoW = 2;
  localparam int SyncW = 3 * PortW + TwoW;
  // Bit positions inside the synchroniser vector
  localparam int SyncD = 0;
  localparam int SyncS = 4;
  localparam int SyncG = 8;
  localparam int SyncF = 12;
  // Shared-pin positions
  localparam int BitC = 2;
  localparam int BitK = 3;
  localparam int BitInt = 0;
  localparam int BitTout = 1;
  // Control register fields
  localparam int PullupG = 0;
  localparam int PullupCK = 1;
  localparam int KeyonS = 0;
  localparam int KeyonG = 1;
  localparam int KeyonInt = 2;
  // Reset values
  localparam logic [3:0] LatchRst4 = 4'hf;
  localparam logic [1:0] LatchRst2 = 2'h3;
  localparam logic [1:0] PullupRst = 2'h0;
  localparam logic [2:0] KeyonRst = 3'h0;
  localparam logic [1:0] LogicSelRst = 2'h0;
  localparam logic [1:0] LogicSelBackup = 2'h0;
  // Logic operation select codes
  localparam logic [1:0] OpXor = 2'h0;
  localparam logic [1:0] OpOr = 2'h1;
  localparam logic [1:0] OpAnd = 2'h2;
endpackage

// >>> hw/pin_sync.sv
// Two-flop synchroniser for the port pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Raw and synchronised levels
  input wire logic [W-1:0] async,
  output logic [W-1:0] synced
);
  logic [W-1:0] firstReg;

  // Pins idle high (released, pulled up), so reset to ones
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (rst) begin
        firstReg[i] <= 1'b1;
        synced[i] <= 1'b1;
      end else begin
        firstReg[i] <= async[i];
        synced[i] <= firstReg[i];
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/open_drain_port_set_with_wakeup.sv
// Port latches, open-drain drive, pull-ups, wakeup and logic op
`timescale 1ns/10ps
`default_nettype none
module open_drain_port_set_with_wakeup (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // CPU data and strobes
  input wire logic [3:0] wrData,
  input wire logic [1:0] dBitSel,
  input wire logic dBitSetStb,
  input wire logic dBitClrStb,
  input wire logic dAllSetStb,
  input wire logic cSetStb,
  input wire logic cClrStb,
  input wire logic kWrStb,
  input wire logic sWrStb,
  input wire logic gWrStb,
  input wire logic fWrStb,
  input wire logic pullupWrStb,
  input wire logic keyonWrStb,
  input wire logic logicSelWrStb,
  input wire logic logicOpStb,
  input wire logic [3:0] accIn,
  input wire logic powerDownStb,
  // Timer link
  input wire logic timerUnderflow,
  input wire logic timerOutEn,
  // Read-back
  output logic [3:0] dRead,
  output logic dBitRead,
  output logic cRead,
  output logic kRead,
  output logic [3:0] sRead,
  output logic [3:0] gRead,
  output logic [1:0] fRead,
  output logic [3:0] logicOpResult,
  // Interrupt and backup
  output logic extIntLevel,
  output logic inBackup,
  output logic wakeReturnReq,
  // Pins
  input wire logic [3:0] dPinIn,
  output logic [3:0] dPinOut,
  output logic [3:0] dPinOe,
  input wire logic [3:0] sPinIn,
  output logic [3:0] sPinOut,
  output logic [3:0] sPinOe,
  input wire logic [3:0] gPinIn,
  output logic [3:0] gPinOut,
  output logic [3:0] gPinOe,
  input wire logic [1:0] fPinIn,
  output logic [1:0] fPinOut,
  output logic [1:0] fPinOe,
  output logic gPullupEn,
  output logic ckPullupEn
);
  logic [3:0] dLatchReg;
  logic [3:0] sLatchReg;
  logic [3:0] gLatchReg;
  logic [1:0] fLatchReg;
  logic cLatchReg;
  logic kLatchReg;
  logic [1:0] pullupReg;
  logic [2:0] keyonReg;
  logic [1:0] logicSelReg;
  logic toutReg;
  logic backupReg;
  logic [port_set_pkg::SyncW-1:0] pinSync;
  logic wakeLow;
  logic [3:0] logicNext;

  pin_sync #(.W(port_set_pkg::SyncW)) pin_sync_i (
    .mclk(mclk),
    .rst(rst),
    .async({fPinIn, gPinIn, sPinIn, dPinIn}),
    .synced(pinSync)
  );

  // Synchroniser outputs are flops, so reads come straight off them
  assign dRead = pinSync[port_set_pkg::SyncD +: 4];
  assign sRead = pinSync[port_set_pkg::SyncS +: 4];
  assign gRead = pinSync[port_set_pkg::SyncG +: 4];
  assign fRead = pinSync[port_set_pkg::SyncF +: 2];
  assign dBitRead = dRead[dBitSel];
  assign cRead = dRead[port_set_pkg::BitC];
  assign kRead = dRead[port_set_pkg::BitK];
  assign extIntLevel = gRead[port_set_pkg::BitInt];

  always_ff @(posedge mclk) begin
    if (rst) begin
      dLatchReg <= port_set_pkg::LatchRst4;
    end else if (dAllSetStb) begin
      dLatchReg <= port_set_pkg::LatchRst4;
    end else if (dBitSetStb) begin
      dLatchReg[dBitSel] <= 1'b1;
    end else if (dBitClrStb) begin
      dLatchReg[dBitSel] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cLatchReg <= 1'b1;
      kLatchReg <= 1'b1;
    end else begin
      if (cSetStb) begin
        cLatchReg <= 1'b1;
      end else if (cClrStb) begin
        cLatchReg <= 1'b0;
      end
      if (kWrStb) begin
        kLatchReg <= wrData[0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sLatchReg <= port_set_pkg::LatchRst4;
      gLatchReg <= port_set_pkg::LatchRst4;
      fLatchReg <= port_set_pkg::LatchRst2;
    end else begin
      if (sWrStb) begin
        sLatchReg <= wrData;
      end
      if (gWrStb) begin
        gLatchReg <= wrData;
      end
      if (fWrStb) begin
        fLatchReg <= wrData[1:0];
      end
    end
  end

  // Pull-ups survive backup; only reset or a control write clears them
  always_ff @(posedge mclk) begin
    if (rst) begin
      pullupReg <= port_set_pkg::PullupRst;
      keyonReg <= port_set_pkg::KeyonRst;
    end else begin
      if (pullupWrStb) begin
        pullupReg <= wrData[1:0];
      end
      if (keyonWrStb) begin
        keyonReg <= wrData[2:0];
      end
    end
  end

  assign gPullupEn = pullupReg[port_set_pkg::PullupG];
  assign ckPullupEn = pullupReg[port_set_pkg::PullupCK];

  // Drive low only; a latch of 1 releases the pin
  assign dPinOut = 4'h0;
  assign sPinOut = 4'h0;
  assign gPinOut = 4'h0;
  assign fPinOut = 2'h0;
  always_comb begin
    dPinOe = ~dLatchReg;
    dPinOe[port_set_pkg::BitC] = ~dLatchReg[port_set_pkg::BitC] |
      ~cLatchReg;
    dPinOe[port_set_pkg::BitK] = ~dLatchReg[port_set_pkg::BitK] |
      ~kLatchReg;
    sPinOe = ~sLatchReg;
    fPinOe = ~fLatchReg;
    gPinOe = ~gLatchReg;
    gPinOe[port_set_pkg::BitTout] = ~gLatchReg[port_set_pkg::BitTout] |
      (timerOutEn & ~toutReg);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      toutReg <= 1'b1;
    end else if (timerUnderflow) begin
      toutReg <= ~toutReg;
    end
  end

  // Pins tied low with wakeup enabled return at once from backup
  assign wakeLow =
    (keyonReg[port_set_pkg::KeyonInt] & ~gRead[port_set_pkg::BitInt]) |
    (keyonReg[port_set_pkg::KeyonG] & ~&gRead[3:1]) |
    (keyonReg[port_set_pkg::KeyonS] & ~&sRead);
  assign wakeReturnReq = backupReg & wakeLow;
  assign inBackup = backupReg;

  always_ff @(posedge mclk) begin
    if (rst) begin
      backupReg <= 1'b0;
    end else if (powerDownStb) begin
      backupReg <= 1'b1;
    end else if (wakeReturnReq) begin
      backupReg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      logicSelReg <= port_set_pkg::LogicSelRst;
    end else if (powerDownStb) begin
      logicSelReg <= port_set_pkg::LogicSelBackup;
    end else if (logicSelWrStb) begin
      logicSelReg <= wrData[1:0];
    end
  end

  // The unused select code leaves the accumulator as it was
  always_comb begin
    case (logicSelReg)
      port_set_pkg::OpXor: logicNext = accIn ^ sRead;
      port_set_pkg::OpOr: logicNext = accIn | sRead;
      port_set_pkg::OpAnd: logicNext = accIn & sRead;
      default: logicNext = accIn;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      logicOpResult <= 4'h0;
    end else if (logicOpStb) begin
      logicOpResult <= logicNext;
    end
  end

  property p_tout_toggle;
    @(posedge mclk) disable iff (rst)
      timerUnderflow |=> toutReg != $past(toutReg);
  endproperty
  a_tout_toggle: assert property (p_tout_toggle)
    else $error("timer output did not toggle on underflow");

  property p_tout_drive;
    @(posedge mclk) disable iff (rst)
      timerOutEn && !toutReg |-> gPinOe[port_set_pkg::BitTout];
  endproperty
  a_tout_drive: assert property (p_tout_drive)
    else $error("timer output low not driven on shared pin");

  property p_d_bit_clear;
    @(posedge mclk) disable iff (rst)
      dBitClrStb && !dBitSetStb && !dAllSetStb && dBitSel == 2'h1
      |=> dPinOe[1] && dLatchReg[0] == $past(dLatchReg[0]);
  endproperty
  a_d_bit_clear: assert property (p_d_bit_clear)
    else $error("selected port bit not cleared alone");

  property p_all_release;
    @(posedge mclk) disable iff (rst)
      dAllSetStb && !cClrStb && !(kWrStb && !wrData[0]) &&
      cLatchReg && kLatchReg |=> dPinOe == 4'h0;
  endproperty
  a_all_release: assert property (p_all_release)
    else $error("port pins not released after set-all");

  property p_shared_low;
    @(posedge mclk) disable iff (rst)
      (cClrStb || !cLatchReg) && !cSetStb |=> dPinOe[port_set_pkg::BitC];
  endproperty
  a_shared_low: assert property (p_shared_low)
    else $error("shared pin not driven while single-bit latch low");

  property p_int_pin_usable;
    @(posedge mclk) disable iff (rst)
      timerOutEn |-> gPinOe[port_set_pkg::BitInt] ==
      !gLatchReg[port_set_pkg::BitInt];
  endproperty
  a_int_pin_usable: assert property (p_int_pin_usable)
    else $error("interrupt pin output disturbed by timer select");

  property p_read_sync;
    @(posedge mclk) disable iff (rst)
      !$past(rst, 2) |-> gRead == $past(gPinIn, 2);
  endproperty
  a_read_sync: assert property (p_read_sync)
    else $error("port read is not the pin two cycles back");

  property p_wake_now;
    @(posedge mclk) disable iff (rst)
      powerDownStb && keyonReg[port_set_pkg::KeyonS] && !keyonWrStb &&
      sRead != 4'hf && sPinIn != 4'hf && $past(sPinIn) != 4'hf
      |=> wakeReturnReq ##1 !inBackup;
  endproperty
  a_wake_now: assert property (p_wake_now)
    else $error("low wakeup pin did not end backup at once");

  property p_pullup_write;
    @(posedge mclk) disable iff (rst)
      pullupWrStb |=> gPullupEn == $past(wrData[0]) &&
      ckPullupEn == $past(wrData[1]);
  endproperty
  a_pullup_write: assert property (p_pullup_write)
    else $error("pull-up enables do not follow control write");

  property p_logic_xor;
    @(posedge mclk) disable iff (rst)
      logicOpStb && logicSelReg == port_set_pkg::OpXor
      |=> logicOpResult == ($past(accIn) ^ $past(sRead));
  endproperty
  a_logic_xor: assert property (p_logic_xor)
    else $error("logic op XOR result wrong");
endmodule
`default_nettype wire

// >>> tb/pin_load_model.sv
// Pin loads: keys to ground, board resistors and switched pull-ups
`timescale 1ns/10ps
`default_nettype none
module pin_load_model (
  // Drive enables and pull-up controls from the port set
  input wire logic [3:0] dPinOe,
  input wire logic [3:0] sPinOe,
  input wire logic [3:0] gPinOe,
  input wire logic [1:0] fPinOe,
  input wire logic gPullupEn,
  input wire logic ckPullupEn,
  // Keys closed to ground
  input wire logic [3:0] sKey,
  input wire logic [3:0] gKey,
  // Pin levels
  output logic [3:0] dPinIn,
  output logic [3:0] sPinIn,
  output logic [3:0] gPinIn,
  output logic [1:0] fPinIn
);
  // Resistors hold the low bit-addressable pins, logic and two-bit pins
  // high; wake pins and shared pins leak to ground unless their
  // pull-ups are on, so a dead pull-up reads as 0
  assign dPinIn[1:0] = ~dPinOe[1:0];
  assign dPinIn[3:2] = ~dPinOe[3:2] & {2{ckPullupEn}};
  assign sPinIn = ~(sPinOe | sKey);
  assign gPinIn = ~(gPinOe | gKey) & {4{gPullupEn}};
  assign fPinIn = ~fPinOe;
endmodule
`default_nettype wire

// >>> tb/open_drain_port_set_with_wakeup_tb.sv
// Self-checking bench for the open-drain port set
`timescale 1ns/10ps
`default_nettype none
module open_drain_port_set_with_wakeup_tb;
  localparam int DSet = 0, DClr = 1, DAll = 2, CSet = 3, CClr = 4;
  localparam int KWr = 5, SWr = 6, GWr = 7, FWr = 8, PuWr = 9, KoWr = 10;
  localparam int LSel = 11, LOp = 12, Pd = 13, TUf = 14;
  logic mclk, rst, timerOutEn, dBitRead, cRead, kRead;
  logic extIntLevel, inBackup, wakeReturnReq, gPullupEn, ckPullupEn;
  logic [14:0] stb;
  logic [1:0] dBitSel, fRead, fPinIn, fPinOut, fPinOe;
  logic [3:0] wrData, accIn, dRead, sRead, gRead, logicOpResult, sKey;
  logic [3:0] dPinIn, dPinOut, dPinOe, sPinIn, sPinOut, sPinOe, gKey;
  logic [3:0] gPinIn, gPinOut, gPinOe;
  int fail_count, n_checks;

  open_drain_port_set_with_wakeup open_drain_port_set_with_wakeup_i (
    .mclk, .rst, .wrData, .dBitSel, .dBitSetStb(stb[DSet]),
    .dBitClrStb(stb[DClr]), .dAllSetStb(stb[DAll]), .cSetStb(stb[CSet]),
    .cClrStb(stb[CClr]), .kWrStb(stb[KWr]), .sWrStb(stb[SWr]),
    .gWrStb(stb[GWr]), .fWrStb(stb[FWr]), .pullupWrStb(stb[PuWr]),
    .keyonWrStb(stb[KoWr]), .logicSelWrStb(stb[LSel]),
    .logicOpStb(stb[LOp]), .accIn, .powerDownStb(stb[Pd]),
    .timerUnderflow(stb[TUf]), .timerOutEn, .dRead, .dBitRead, .cRead,
    .kRead, .sRead, .gRead, .fRead, .logicOpResult, .extIntLevel,
    .inBackup, .wakeReturnReq, .dPinIn, .dPinOut, .dPinOe, .sPinIn,
    .sPinOut, .sPinOe, .gPinIn, .gPinOut, .gPinOe, .fPinIn, .fPinOut,
    .fPinOe, .gPullupEn, .ckPullupEn);
  pin_load_model pin_load_model_i (.dPinOe, .sPinOe, .gPinOe, .fPinOe,
    .gPullupEn, .ckPullupEn, .sKey, .gKey, .dPinIn, .sPinIn, .gPinIn,
    .fPinIn);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Leading wait keeps two pulses from touching stb in one time step
  task automatic pulse(input int idx, input logic [3:0] d);
    step(1);
    wrData = d;
    stb[idx] = 1'b1;
    step(1);
    stb[idx] = 1'b0;
  endtask

  task automatic t_reset;
    chk(dPinOe | sPinOe | gPinOe, 4'h0);
    chk({fPinOe, gPullupEn, ckPullupEn}, 4'h0);
    chk({2'h0, inBackup, wakeReturnReq}, 4'h0);
    chk(logicOpResult, 4'h0);
    chk(dPinOut | sPinOut | gPinOut, 4'h0);
    chk({2'h0, fPinOut}, 4'h0);
  endtask

  task automatic t_pullup;
    chk(gRead, 4'h0);
    pulse(PuWr, 4'h1);
    step(1);
    chk({2'h0, gPullupEn, ckPullupEn}, 4'h2);
    pulse(PuWr, 4'h3);
    step(2);
    chk({2'h0, gPullupEn, ckPullupEn}, 4'h3);
    chk(gRead, 4'hf);
    chk(dRead, 4'hf);
  endtask

  task automatic t_dbits;
    for (int i = 0; i < 4; i++) begin
      dBitSel = i[1:0];
      pulse(DClr, 4'h0);
      chk(dPinOe, 4'h1 << i);
      step(2);
      chk({3'h0, dBitRead}, 4'h0);
      pulse(DSet, 4'h0);
      chk(dPinOe, 4'h0);
    end
    pulse(DClr, 4'h0);
    dBitSel = 2'h0;
    pulse(DClr, 4'h0);
    pulse(DAll, 4'h0);
    chk(dPinOe, 4'h0);
  endtask

  task automatic t_ck;
    pulse(CClr, 4'h0);
    chk(dPinOe, 4'h4);
    step(2);
    chk({2'h0, cRead, kRead}, 4'h1);
    pulse(CSet, 4'h0);
    pulse(KWr, 4'h0);
    chk(dPinOe, 4'h8);
    pulse(KWr, 4'h1);
    chk(dPinOe, 4'h0);
  endtask

  task automatic t_ports;
    pulse(SWr, 4'ha);
    chk(sPinOe, 4'h5);
    pulse(GWr, 4'h5);
    chk(gPinOe, 4'ha);
    pulse(FWr, 4'h2);
    chk({2'h0, fPinOe}, 4'h1);
    step(2);
    chk(sRead, 4'ha);
    chk(gRead, 4'h5);
    chk({2'h0, fRead}, 4'h2);
    pulse(SWr, 4'hf);
    pulse(GWr, 4'hf);
    pulse(FWr, 4'h3);
  endtask

  task automatic t_logic;
    logic [3:0] e;
    sKey = 4'h6;
    accIn = 4'hc;
    for (int op = 0; op < 4; op++) begin
      pulse(LSel, op[3:0]);
      pulse(LOp, 4'h0);
      e = op == 0 ? accIn ^ 4'h9 : op == 1 ? accIn | 4'h9 :
          op == 2 ? accIn & 4'h9 : accIn;
      chk(logicOpResult, e);
    end
    sKey = 4'h0;
  endtask

  task automatic t_timer;
    timerOutEn = 1'b1;
    pulse(TUf, 4'h0);
    chk(gPinOe, 4'h2);
    pulse(TUf, 4'h0);
    chk(gPinOe, 4'h0);
    gKey = 4'h3;
    step(2);
    chk({3'h0, extIntLevel}, 4'h0);
    chk(gRead, 4'hc);
    gKey = 4'h0;
    step(2);
    chk({3'h0, extIntLevel}, 4'h1);
    timerOutEn = 1'b0;
  endtask

  // Per source: keys of other groups must not wake, its own must
  task automatic t_wake;
    logic [7:0] own [3] = '{8'h10, 8'h04, 8'h01};
    logic [7:0] other [3] = '{8'h0f, 8'hf1, 8'hfe};
    for (int i = 0; i < 3; i++) begin
      {sKey, gKey} = other[i];
      pulse(KoWr, 4'h1 << i);
      pulse(Pd, 4'h0);
      chk({2'h0, inBackup, wakeReturnReq}, 4'h2);
      {sKey, gKey} = own[i];
      step(3);
      chk({3'h0, inBackup}, 4'h0);
      pulse(Pd, 4'h0);
      chk({2'h0, inBackup, wakeReturnReq}, 4'h3);
      step(1);
      chk({3'h0, inBackup}, 4'h0);
    end
    {sKey, gKey} = 8'h00;
    step(2);
    // Backup entry put the select back to XOR after the keep code
    pulse(LOp, 4'h0);
    chk(logicOpResult, accIn ^ 4'hf);
  endtask

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #50000;
    fail_count++;
    summarize;
  end

  initial begin
    rst = 1'b1;
    stb = 15'h0000;
    wrData = 4'h0;
    accIn = 4'h0;
    dBitSel = 2'h0;
    timerOutEn = 1'b0;
    sKey = 4'h0;
    gKey = 4'h0;
    fail_count = 0;
    n_checks = 0;
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    step(2);
    t_reset;
    t_pullup;
    t_dbits;
    t_ck;
    t_ports;
    t_logic;
    t_timer;
    t_wake;
    summarize;
  end
endmodule
`default_nettype wire
